// *** rtl/pdh_pkg.sv ***
// Constants and types shared by the parallel converter host controller
package pdh_pkg;

  // ==========================================================
  // Widths and clock
  // ==========================================================
  localparam int DATA_W = 16;
  localparam int CNT_W = 4;
  localparam int SYNC_STAGES = 2;
  localparam int CLK_PERIOD_PS = 25000;

  // ==========================================================
  // Pin timing in nanoseconds
  // ==========================================================
  localparam int T_RDS_NS = 10;
  localparam int T_RCS_NS = 90;
  localparam int T_CSD_NS = 100;
  localparam int T_RDH_NS = 10;
  localparam int T_DZ_NS = 70;
  localparam int T_WS_NS = 10;
  localparam int T_WCS_NS = 25;
  localparam int T_WH_NS = 10;
  localparam int T_DH_NS = 20;
  localparam int T_LWD_NS = 20;
  localparam int T_LS_NS = 30;
  localparam int T_RSS_NS = 30;
  localparam int T_SS_NS = 0;
  localparam int T_SH_NS = 10;

  // Least time to whole cycles, never below one
  function automatic int nsToCycles(input int ns);
    int c;
    c = (ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    return (c < 1) ? 1 : c;
  endfunction

  function automatic int maxOf(input int a, input int b);
    return (a > b) ? a : b;
  endfunction

  // ==========================================================
  // Phase lengths in cycles
  // ==========================================================
  localparam int C_RDS = nsToCycles(T_RDS_NS);
  localparam int C_RD_ACT = maxOf(nsToCycles(T_RCS_NS), nsToCycles(T_CSD_NS) + SYNC_STAGES + 1);
  localparam int C_RDH = nsToCycles(T_RDH_NS);
  localparam int C_DZ = nsToCycles(T_DZ_NS);
  localparam int C_WS = nsToCycles(T_WS_NS);
  localparam int C_WCS = nsToCycles(T_WCS_NS);
  localparam int C_WR_HOLD = maxOf(nsToCycles(T_DH_NS), nsToCycles(T_WH_NS));
  localparam int C_LWD = nsToCycles(T_LWD_NS);
  localparam int C_DIR_ACT = maxOf(nsToCycles(T_LS_NS), nsToCycles(T_LWD_NS));
  localparam int C_RSS = nsToCycles(T_RSS_NS);
  localparam int C_SS = nsToCycles(T_SS_NS);
  localparam int C_SH = nsToCycles(T_SH_NS);
  localparam int C_ONE = 1;

  // ==========================================================
  // Reset values of the pins
  // ==========================================================
  localparam logic PIN_INACTIVE = 1'b1;
  localparam logic RSEL_RESET = 1'b0;
  localparam logic [DATA_W-1:0] DATA_RESET = 16'h0000;

  // ==========================================================
  // Commands and states
  // ==========================================================
  typedef enum logic [2:0] {
    CMD_WRITE = 3'h0,
    CMD_READ = 3'h1,
    CMD_LOAD = 3'h2,
    CMD_DIRECT = 3'h3,
    CMD_RESET = 3'h4
  } pdh_cmd_type;

  typedef enum logic [4:0] {
    S_IDLE = 5'h01,
    S_SETUP = 5'h02,
    S_ACTIVE = 5'h04,
    S_HOLD = 5'h08,
    S_GAP = 5'h10
  } pdh_state_type;

endpackage

// *** rtl/pdh_host.sv ***
// Host controller that drives the parallel converter pins
// Contract
// - Bus accesses happen only with chip select low; otherwise ignored.
// - Read/write high reads the holding register, low writes it.
// - Direct update keeps chip select low 30 ns before load strobe rises.
// - Host holds write data 20 ns after chip select rises.
// - Reset select valid at reset fall and stable 10 ns after release.
// - The reserved test input is tied to digital ground.
`timescale 1ns/1ps
`default_nettype none

module pdh_host
  import pdh_pkg::*;
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic cmdValid,
  input wire pdh_cmd_type cmdKind,
  input wire logic [DATA_W-1:0] cmdData,
  input wire logic cmdResetMid,
  input wire logic refEnable,
  output logic cmdReady,
  output logic [DATA_W-1:0] rdData,
  output logic rdValid,
  output logic chipSelectN,
  output logic readWrite,
  output logic [DATA_W-1:0] parallelDataLinesOut,
  output logic parallelDataLinesOeN,
  input wire logic [DATA_W-1:0] parallelDataLinesIn,
  output logic converterLoadStrobeN,
  output logic outputResetN,
  output logic resetLevelSelect,
  output logic internalReferenceEnableN,
  output logic testToDigitalGround
);

  // ==========================================================
  // State record
  // ==========================================================
  typedef struct packed {
    pdh_state_type state;
    pdh_cmd_type kind;
    logic [CNT_W-1:0] cnt;
    logic ready;
    logic [DATA_W-1:0] rdData;
    logic rdValid;
    logic csN;
    logic rw;
    logic [DATA_W-1:0] dataOut;
    logic oeN;
    logic loadN;
    logic rstN;
    logic reset_level_select;
    logic refEnN;
    logic testTie;
    logic [DATA_W-1:0] dataMeta;
    logic [DATA_W-1:0] dataSync;
  } pdh_regs_type;

  pdh_regs_type st_q;
  pdh_regs_type st_d;

  // Remaining cycles of a phase, stored as length minus one
  function automatic logic [CNT_W-1:0] phaseCount(input pdh_cmd_type k, input pdh_state_type s);
    int n;
    n = C_ONE;
    unique case (s)
      S_SETUP: n = (k == CMD_READ) ? C_RDS : (k == CMD_RESET) ? C_SS
                 : (k == CMD_LOAD) ? C_ONE : C_WS;
      S_ACTIVE: n = (k == CMD_READ) ? C_RD_ACT : (k == CMD_RESET) ? C_RSS
                  : (k == CMD_LOAD) ? C_LWD : (k == CMD_DIRECT) ? C_DIR_ACT : C_WCS;
      S_HOLD: n = (k == CMD_READ) ? C_RDH : (k == CMD_RESET) ? C_SH
                : (k == CMD_LOAD) ? C_ONE : C_WR_HOLD;
      S_GAP: n = C_DZ;
      default: n = C_ONE;
    endcase
    return CNT_W'(n - 1);
  endfunction

  // ==========================================================
  // Next state
  // ==========================================================
  // Sequencer of setup, active, hold and bus turnaround phases
  always_comb begin
    st_d = st_q;
    st_d.dataMeta = parallelDataLinesIn;
    st_d.dataSync = st_q.dataMeta;
    st_d.refEnN = ~refEnable;
    st_d.testTie = 1'b0;
    st_d.rdValid = 1'b0;
    if (st_q.cnt != '0) begin
      st_d.cnt = st_q.cnt - CNT_W'(1);
    end
    unique case (st_q.state)
      S_IDLE: begin
        if (cmdValid) begin
          st_d.kind = cmdKind;
          st_d.ready = 1'b0;
          st_d.state = S_SETUP;
          st_d.cnt = phaseCount(cmdKind, S_SETUP);
          // Direction settles before select falls
          if (cmdKind == CMD_WRITE || cmdKind == CMD_DIRECT) begin
            st_d.rw = 1'b0;
            st_d.dataOut = cmdData;
            st_d.oeN = 1'b0;
          end
          if (cmdKind == CMD_READ) begin
            st_d.rw = 1'b1;
          end
          if (cmdKind == CMD_RESET) begin
            st_d.reset_level_select = cmdResetMid;
          end
        end
      end
      S_SETUP: begin
        if (st_q.cnt == '0) begin
          st_d.state = S_ACTIVE;
          st_d.cnt = phaseCount(st_q.kind, S_ACTIVE);
          if (st_q.kind == CMD_WRITE || st_q.kind == CMD_READ || st_q.kind == CMD_DIRECT) begin
            st_d.csN = 1'b0;
          end
          if (st_q.kind == CMD_LOAD || st_q.kind == CMD_DIRECT) begin
            st_d.loadN = 1'b0;
          end
          if (st_q.kind == CMD_RESET) begin
            st_d.rstN = 1'b0;
          end
        end
      end
      S_ACTIVE: begin
        if (st_q.cnt == '0) begin
          st_d.state = S_HOLD;
          st_d.cnt = phaseCount(st_q.kind, S_HOLD);
          st_d.csN = 1'b1;
          st_d.loadN = 1'b1;
          st_d.rstN = 1'b1;
          if (st_q.kind == CMD_READ) begin
            st_d.rdData = st_q.dataSync;
            st_d.rdValid = 1'b1;
          end
        end
      end
      S_HOLD: begin
        // Data and direction outlast the select edge
        if (st_q.cnt == '0) begin
          st_d.oeN = 1'b1;
          st_d.rw = 1'b1;
          if (st_q.kind == CMD_READ) begin
            st_d.state = S_GAP;
            st_d.cnt = phaseCount(st_q.kind, S_GAP);
          end else begin
            st_d.state = S_IDLE;
            st_d.ready = 1'b1;
          end
        end
      end
      S_GAP: begin
        // Wait for the device to let go of the bus
        if (st_q.cnt == '0) begin
          st_d.state = S_IDLE;
          st_d.ready = 1'b1;
        end
      end
      default: begin
        st_d.state = S_IDLE;
        st_d.ready = 1'b1;
        st_d.csN = 1'b1;
        st_d.oeN = 1'b1;
        st_d.loadN = 1'b1;
        st_d.rstN = 1'b1;
      end
    endcase
  end

  // ==========================================================
  // State register
  // ==========================================================
  // Pins park inactive under reset
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      st_q.state <= S_IDLE;
      st_q.kind <= CMD_WRITE;
      st_q.cnt <= '0;
      st_q.ready <= 1'b1;
      st_q.rdData <= DATA_RESET;
      st_q.rdValid <= 1'b0;
      st_q.csN <= PIN_INACTIVE;
      st_q.rw <= PIN_INACTIVE;
      st_q.dataOut <= DATA_RESET;
      st_q.oeN <= PIN_INACTIVE;
      st_q.loadN <= PIN_INACTIVE;
      st_q.rstN <= PIN_INACTIVE;
      st_q.reset_level_select <= RSEL_RESET;
      st_q.refEnN <= PIN_INACTIVE;
      st_q.testTie <= 1'b0;
      st_q.dataMeta <= DATA_RESET;
      st_q.dataSync <= DATA_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  // Outputs straight from the state record
  assign cmdReady = st_q.ready;
  assign rdData = st_q.rdData;
  assign rdValid = st_q.rdValid;
  assign chipSelectN = st_q.csN;
  assign readWrite = st_q.rw;
  assign parallelDataLinesOut = st_q.dataOut;
  assign parallelDataLinesOeN = st_q.oeN;
  assign converterLoadStrobeN = st_q.loadN;
  assign outputResetN = st_q.rstN;
  assign resetLevelSelect = st_q.reset_level_select;
  assign internalReferenceEnableN = st_q.refEnN;
  assign testToDigitalGround = st_q.testTie;

  // ==========================================================
  // Checks
  // ==========================================================
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  sequence s_csLowTwo;
    !chipSelectN ##1 !chipSelectN;
  endsequence

  sequence s_rstLowTwo;
    !outputResetN ##1 !outputResetN;
  endsequence

  property p_rwStableSelected;
    !chipSelectN |-> $stable(readWrite);
  endproperty
  a_rwStableSelected: assert property (p_rwStableSelected)
    else $error("read/write moved while selected");

  property p_busDirection;
    !chipSelectN |-> (parallelDataLinesOeN == readWrite);
  endproperty
  a_busDirection: assert property (p_busDirection)
    else $error("bus drive does not match access direction");

  // Direct update: select stays low two cycles while load is still low
  property p_directSetup;
    ($fell(converterLoadStrobeN) && $fell(chipSelectN) && !readWrite)
      |-> (s_csLowTwo ##0 !converterLoadStrobeN);
  endproperty
  a_directSetup: assert property (p_directSetup)
    else $error("select too short before load rise");

  property p_writeHold;
    ($rose(chipSelectN) && !readWrite) |-> (!parallelDataLinesOeN && $stable(parallelDataLinesOut));
  endproperty
  a_writeHold: assert property (p_writeHold)
    else $error("write data not held after select rise");

  property p_rstSelHold;
    $rose(outputResetN) |-> $stable(resetLevelSelect) ##1 $stable(resetLevelSelect);
  endproperty
  a_rstSelHold: assert property (p_rstSelHold)
    else $error("reset select changed around reset release");

  property p_rstPulse;
    $fell(outputResetN) |-> $stable(resetLevelSelect) ##0 s_rstLowTwo;
  endproperty
  a_rstPulse: assert property (p_rstPulse)
    else $error("reset pulse short or select moved");

  property p_testTie;
    testToDigitalGround == 1'b0;
  endproperty
  a_testTie: assert property (p_testTie)
    else $error("test pin not grounded");

  property p_readCapture;
    rdValid |-> (rdData == $past(st_q.dataSync)) && $rose(chipSelectN) && readWrite;
  endproperty
  a_readCapture: assert property (p_readCapture)
    else $error("read word not taken from synchronised bus");

endmodule // pdh_host

`default_nettype wire

// *** tb/pdh_device_model.sv ***
// Behavioural model of the parallel converter seen by the host controller
`timescale 1ns/1ps
`default_nettype none

module pdh_device_model (
  input wire logic csN,
  input wire logic rw,
  input wire logic loadStrobeN,
  input wire logic rstN,
  input wire logic rsel,
  input wire logic refEnN,
  input wire logic [15:0] dataIn,
  output logic [15:0] dataOut,
  output logic refOn
);
  int readDelayNs = 20;
  logic [15:0] inReg;
  logic [15:0] dacReg;
  logic [15:0] lastOut = 16'h0000;
  logic drive = 1'b0;

  // Released bus shows the inverse of the last driven word
  assign dataOut = drive ? lastOut : ~lastOut;
  assign refOn = (refEnN === 1'b0);

  // Level-sensitive reset, load and transparent paths
  always @(csN or rw or loadStrobeN or dataIn or rstN or rsel) begin
    if (rstN === 1'b0) begin
      dacReg = (rsel === 1'b1) ? 16'h7fff : 16'hffff;
    end else if (loadStrobeN === 1'b0) begin
      if (csN === 1'b0 && rw === 1'b0) inReg = dataIn;
      dacReg = inReg;
    end
  end

  // Read drives the bus after the access delay
  always @(negedge csN) begin
    if (rw === 1'b1) begin
      #(readDelayNs);
      if (csN === 1'b0) begin
        lastOut = inReg;
        drive = 1'b1;
      end
    end
  end

  // Write capture on select rising, bus release after a read
  always @(posedge csN) begin
    if (rw === 1'b0) begin
      inReg = dataIn;
      if (loadStrobeN === 1'b0) dacReg = inReg;
    end
    if (drive) begin
      #40;
      drive = 1'b0;
    end
  end
endmodule // pdh_device_model

`default_nettype wire

// *** tb/parallel_dac_host_interface_bench.sv ***
// Self-checking bench for the parallel converter host controller
`timescale 1ns/1ps
`default_nettype none

module parallel_dac_host_interface_bench;
  import pdh_pkg::*;

  logic core_clk, nrst, cmdValid, cmdResetMid, refEnable;
  pdh_cmd_type cmdKind;
  logic [15:0] cmdData, rdData, busOut, busWire, devOut, got;
  logic cmdReady, rdValid, csN, rw, oeN, loadStrobeN, rstN, rsel, refEnN, testGnd, refOn;
  int fail_count = 0;
  int samples_checked = 0;

  // ==========================================================
  // Clock, wire resolution and instances
  // ==========================================================
  always #12.5 core_clk = ~core_clk;
  assign busWire = (oeN === 1'b0) ? busOut : devOut;

  pdh_host pdh_host_i (.core_clk(core_clk), .nrst(nrst), .cmdValid(cmdValid),
    .cmdKind(cmdKind), .cmdData(cmdData), .cmdResetMid(cmdResetMid),
    .refEnable(refEnable), .cmdReady(cmdReady), .rdData(rdData), .rdValid(rdValid),
    .chipSelectN(csN), .readWrite(rw), .parallelDataLinesOut(busOut),
    .parallelDataLinesOeN(oeN), .parallelDataLinesIn(busWire),
    .converterLoadStrobeN(loadStrobeN), .outputResetN(rstN), .resetLevelSelect(rsel),
    .internalReferenceEnableN(refEnN), .testToDigitalGround(testGnd));

  pdh_device_model pdh_device_model_i (.csN(csN), .rw(rw), .loadStrobeN(loadStrobeN),
    .rstN(rstN), .rsel(rsel), .refEnN(refEnN), .dataIn(busWire),
    .dataOut(devOut), .refOn(refOn));

  // ==========================================================
  // Shared tasks
  // ==========================================================
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // Issue one command; pester holds a second request up for one cycle while busy
  task automatic do_cmd(input pdh_cmd_type k, input logic [15:0] d, input logic mid,
                        input bit pester);
    int n;
    n = 0;
    while (cmdReady !== 1'b1 && n < 40) begin
      @(negedge core_clk);
      n++;
    end
    cmdKind = k;
    cmdData = d;
    cmdResetMid = mid;
    cmdValid = 1'b1;
    @(negedge core_clk);
    cmdData = ~d;
    cmdValid = pester;
    @(negedge core_clk);
    cmdValid = 1'b0;
    n = 0;
    while (cmdReady !== 1'b1 && n < 40) begin
      if (rdValid === 1'b1) got = rdData;
      @(negedge core_clk);
      n++;
    end
    check({15'h0000, cmdReady}, 16'h0001);
  endtask

  // ==========================================================
  // Scenarios
  // ==========================================================
  task automatic t_idle;
    check({11'h000, rw, csN, loadStrobeN, rstN, oeN}, 16'h001f);
    check({15'h0000, testGnd}, 16'h0000);
  endtask

  task automatic t_ref;
    refEnable = 1'b1;
    repeat (2) @(negedge core_clk);
    check({15'h0000, refOn}, 16'h0001);
    refEnable = 1'b0;
    repeat (2) @(negedge core_clk);
    check({15'h0000, refOn}, 16'h0000);
  endtask

  task automatic t_reset;
    do_cmd(CMD_RESET, 16'h0000, 1'b1, 1'b0);
    check(pdh_device_model_i.dacReg, 16'h7fff);
    check({15'h0000, rsel}, 16'h0001);
    do_cmd(CMD_RESET, 16'h0000, 1'b0, 1'b0);
    check(pdh_device_model_i.dacReg, 16'hffff);
    check({15'h0000, rsel}, 16'h0000);
  endtask

  task automatic t_write_read(input logic [15:0] w, input int delayNs);
    pdh_device_model_i.readDelayNs = delayNs;
    do_cmd(CMD_WRITE, w, 1'b0, 1'b0);
    check(pdh_device_model_i.inReg, w);
    check(pdh_device_model_i.dacReg, 16'hffff);
    got = 16'h0000;
    do_cmd(CMD_READ, 16'h0000, 1'b0, 1'b0);
    check(got, w);
  endtask

  task automatic t_load;
    do_cmd(CMD_LOAD, 16'h0000, 1'b0, 1'b0);
    check(pdh_device_model_i.dacReg, 16'h4c3a);
    check(pdh_device_model_i.inReg, 16'h4c3a);
  endtask

  task automatic t_direct;
    do_cmd(CMD_DIRECT, 16'h2b7e, 1'b0, 1'b0);
    check(pdh_device_model_i.dacReg, 16'h2b7e);
  endtask

  task automatic t_refused;
    do_cmd(CMD_WRITE, 16'h1111, 1'b0, 1'b1);
    repeat (6) @(negedge core_clk);
    check(pdh_device_model_i.inReg, 16'h1111);
  endtask

  // ==========================================================
  // Main sequence and watchdog
  // ==========================================================
  initial begin
    core_clk = 1'b0;
    nrst = 1'b0;
    cmdValid = 1'b0;
    cmdKind = CMD_WRITE;
    cmdData = 16'h0000;
    cmdResetMid = 1'b0;
    refEnable = 1'b0;
    repeat (16) @(negedge core_clk);
    nrst = 1'b1;
    @(negedge core_clk);
    t_idle;
    t_ref;
    t_reset;
    t_write_read(16'h8001, 20);
    t_write_read(16'h4c3a, 100);
    t_load;
    t_direct;
    t_refused;
    complete_run;
  end

  initial begin
    #(25 * 4000);
    fail_count++;
    complete_run;
  end
endmodule // parallel_dac_host_interface_bench

`default_nettype wire
